// ---- verilog/ism_pkg.sv ----
// package: register map, field layout and carrier types of the status/mask block
package ism_pkg;
  // register byte addresses, one aligned word each
  localparam logic [7:0] ISM_OFS_STATUS = 8'h00;
  localparam logic [7:0] ISM_OFS_MASK = 8'h04;
  localparam logic [7:0] ISM_OFS_RXBUF = 8'h08;
  localparam logic [7:0] ISM_OFS_TXBUF = 8'h0c;
  localparam logic [7:0] ISM_OFS_OWNADR = 8'h10;
  localparam logic [7:0] ISM_OFS_IRQST = 8'h14;
  localparam logic [7:0] ISM_OFS_IRQMSK = 8'h18;
  // widths
  localparam int ISM_AW = 8;
  localparam int ISM_DW = 32;
  localparam int ISM_ADRW = 10;
  localparam int ISM_ADR7W = 7;
  localparam int ISM_NEV = 5;
  // status register bit positions
  localparam int ISM_ST_TXFULL = 0;
  localparam int ISM_ST_RXFULL = 1;
  localparam int ISM_ST_RW = 2;
  localparam int ISM_ST_START = 3;
  localparam int ISM_ST_STOP = 4;
  // interrupt event bit positions
  localparam int ISM_EV_START = 0;
  localparam int ISM_EV_STOP = 1;
  localparam int ISM_EV_RXFULL = 2;
  localparam int ISM_EV_TXDONE = 3;
  localparam int ISM_EV_MATCH = 4;
  // reset values
  localparam logic [9:0] ISM_MASK_RST = 10'h000;
  localparam logic [9:0] ISM_OWNADR_RST = 10'h000;
  localparam logic [4:0] ISM_IRQMSK_RST = 5'h00;
  localparam logic [31:0] ISM_RD_ZERO = 32'h0000_0000;

  // bus status flags as carried inside the block
  typedef struct packed {
    logic stop_seen;
    logic start_seen;
    logic slave_read;
    logic receive_buffer_full_flag;
    logic transmit_buffer_full_flag;
  } ism_status_t;

  // register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } ism_req_t;
endpackage

// ---- verilog/ism_cond_det.sv ----
// bus condition detector: synchronises the two wires and finds start and stop
`timescale 1ns/1ps
module ism_cond_det (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // raw bus wires
  input wire logic scl_i,
  input wire logic sda_i,
  // detected conditions, one-cycle pulses
  output logic start_o,
  output logic stop_o
);
  logic [1:0] scl_sync_q; // two-stage synchroniser for clock wire
  logic [1:0] sda_sync_q; // two-stage synchroniser for data wire
  logic scl_old_q; // previous synchronised clock level
  logic sda_old_q; // previous synchronised data level

  // synchronisers; stage 0 feeds only stage 1
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
    end else begin
      scl_sync_q <= {scl_sync_q[0], scl_i};
      sda_sync_q <= {sda_sync_q[0], sda_i};
    end
  end

  // history for edge finding, idle bus is high
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_old_q <= 1'b1;
      sda_old_q <= 1'b1;
    end else begin
      scl_old_q <= scl_sync_q[1];
      sda_old_q <= sda_sync_q[1];
    end
  end

  // data falling while clock high is a start, rising is a stop
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      start_o <= 1'b0;
      stop_o <= 1'b0;
    end else begin
      // clock must be high before and after, so a data change on a clock edge is not taken
      start_o <= scl_old_q && scl_sync_q[1] && sda_old_q && !sda_sync_q[1];
      stop_o <= scl_old_q && scl_sync_q[1] && !sda_old_q && sda_sync_q[1];
    end
  end
endmodule

// ---- verilog/ism_top.sv ----
// two-wire bus status flags, slave address mask compare and register port
//
// Behaviour
// R1 - start flag high after start or repeated start
// R2 - stop flag high after stop, low after start
// R3 - hardware updates start flag on every condition
// R4 - direction flag: one for master read, zero write
// R5 - direction taken only from the address byte
// R6 - receive full set when received byte stored
// R7 - receive full cleared by software buffer read
// R8 - transmit full set by software buffer write
// R9 - transmit full cleared when byte transmission completes
// R10 - masked address bits are ignored in compare
// R11 - unmasked address bits must equal own address
// R12 - mask upper six bits read zero, writes ignored
// R13 - seven-bit address uses only low mask bits
//
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
module ism_top (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // register port
  input wire logic [ism_pkg::ISM_AW-1:0] reg_addr_i,
  input wire logic [ism_pkg::ISM_DW-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [ism_pkg::ISM_DW-1:0] reg_rdata_o,
  // bus wires, sampled only
  input wire logic scl_i,
  input wire logic sda_i,
  // from the shifter and sequencer
  input wire logic rx_byte_valid_i,
  input wire logic [7:0] rx_byte_i,
  input wire logic adr_byte_valid_i,
  input wire logic adr_byte_rw_i,
  input wire logic tx_done_i,
  input wire logic adr_cmp_valid_i,
  input wire logic [ism_pkg::ISM_ADRW-1:0] adr_in_i,
  input wire logic adr_ten_bit_i,
  // to the shifter and sequencer
  output logic [7:0] tx_byte_o,
  output logic tx_load_o,
  output logic adr_match_o,
  output logic adr_match_valid_o,
  // interrupt
  output logic irq_o
);
  import ism_pkg::*;

  ism_req_t req; // bundled register request
  ism_status_t status_q; // bus status flags, gathered from the flops below
  logic start_seen_q; // last condition was a start
  logic stop_seen_q; // last condition was a stop
  logic slave_read_q; // master reads from us
  logic receive_buffer_full_flag_q; // receive buffer holds an unread byte
  logic transmit_buffer_full_flag_q; // transmit buffer waits to be sent
  logic [ISM_ADRW-1:0] address_bit_mask_q; // per-bit ignore mask
  logic [ISM_ADRW-1:0] own_adr_q; // own slave address
  logic [7:0] rx_buf_q; // receive buffer register
  logic [ISM_NEV-1:0] irq_st_q; // sticky interrupt status
  logic [ISM_NEV-1:0] irq_msk_q; // interrupt enable mask
  logic [ISM_NEV-1:0] ev; // event pulses this cycle
  logic [ISM_NEV-1:0] irq_w1c; // software clear strobe per bit
  logic start_det; // start or repeated start pulse
  logic stop_det; // stop pulse
  logic [ISM_ADRW-1:0] bit_ok; // per-bit compare result
  logic match_c; // whole address compare
  logic wr_tx; // software write of transmit buffer
  logic rd_rx; // software read of receive buffer
  logic [ISM_DW-1:0] rd_mux; // read data before the register

  assign req = '{wr: reg_wr_i, rd: reg_rd_i, addr: reg_addr_i, wdata: reg_wdata_i};
  assign wr_tx = req.wr && (req.addr == ISM_OFS_TXBUF);
  assign rd_rx = req.rd && (req.addr == ISM_OFS_RXBUF);
  // one flop per flag, so each has a single driving process
  assign status_q = '{stop_seen: stop_seen_q, start_seen: start_seen_q,
                      slave_read: slave_read_q,
                      receive_buffer_full_flag: receive_buffer_full_flag_q,
                      transmit_buffer_full_flag: transmit_buffer_full_flag_q};

  // start and stop detection on the sampled bus wires
  ism_cond_det u_cond (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .start_o(start_det),
    .stop_o(stop_det)
  );

  // start and stop flags: last condition seen wins
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      start_seen_q <= 1'b0;
      stop_seen_q <= 1'b0;
    end else if (start_det) begin
      // start and repeated start look the same on the wires
      start_seen_q <= 1'b1; // [R1] [R3]
      stop_seen_q <= 1'b0; // [R2]
    end else if (stop_det) begin
      start_seen_q <= 1'b0; // [R1] [R3]
      stop_seen_q <= 1'b1; // [R2]
    end
  end

  // direction flag, loaded only from the address byte
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      slave_read_q <= 1'b0;
    end else if (adr_byte_valid_i) begin
      // read/write bit of the address byte, one means master reads
      slave_read_q <= adr_byte_rw_i; // [R4] [R5]
    end
  end

  // receive buffer and its full flag
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_buf_q <= 8'h00;
      receive_buffer_full_flag_q <= 1'b0;
    end else if (rx_byte_valid_i) begin
      // a new byte in the cycle of the read is kept full, not lost
      rx_buf_q <= rx_byte_i;
      receive_buffer_full_flag_q <= 1'b1; // [R6]
    end else if (rd_rx) begin
      receive_buffer_full_flag_q <= 1'b0; // [R7]
    end
  end

  // transmit buffer and its full flag
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_byte_o <= 8'h00;
      transmit_buffer_full_flag_q <= 1'b0;
    end else if (wr_tx) begin
      // software write beats a completion in the same cycle
      tx_byte_o <= req.wdata[7:0];
      transmit_buffer_full_flag_q <= 1'b1; // [R8]
    end else if (tx_done_i) begin
      transmit_buffer_full_flag_q <= 1'b0; // [R9]
    end
  end

  // load pulse tells the shifter a new byte waits
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_load_o <= 1'b0;
    end else begin
      tx_load_o <= wr_tx;
    end
  end

  // mask and own address registers
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      address_bit_mask_q <= ISM_MASK_RST;
      own_adr_q <= ISM_OWNADR_RST;
    end else if (req.wr) begin
      // upper bits of the write are dropped, they have no storage
      if (req.addr == ISM_OFS_MASK) begin
        address_bit_mask_q <= req.wdata[ISM_ADRW-1:0]; // [R12]
      end
      if (req.addr == ISM_OFS_OWNADR) begin
        own_adr_q <= req.wdata[ISM_ADRW-1:0];
      end
    end
  end

  // per-bit masked compare
  generate
    for (genvar i = 0; i < ISM_ADRW; i++) begin : g_cmp
      if (i < ISM_ADR7W) begin : g_low
        // masked bit matches always, otherwise equality needed
        assign bit_ok[i] = address_bit_mask_q[i] || (adr_in_i[i] == own_adr_q[i]); // [R10] [R11]
      end else begin : g_high
        // high bits only take part in a ten-bit address
        assign bit_ok[i] = !adr_ten_bit_i || address_bit_mask_q[i] ||
                           (adr_in_i[i] == own_adr_q[i]); // [R13] [R10] [R11]
      end
    end
  endgenerate
  assign match_c = &bit_ok;

  // registered compare answer
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      adr_match_o <= 1'b0;
      adr_match_valid_o <= 1'b0;
    end else begin
      adr_match_valid_o <= adr_cmp_valid_i;
      if (adr_cmp_valid_i) begin
        adr_match_o <= match_c;
      end
    end
  end

  // event pulses for the interrupt status
  always_comb begin
    ev = '0;
    ev[ISM_EV_START] = start_det;
    ev[ISM_EV_STOP] = stop_det;
    ev[ISM_EV_RXFULL] = rx_byte_valid_i;
    ev[ISM_EV_TXDONE] = tx_done_i;
    ev[ISM_EV_MATCH] = adr_cmp_valid_i && match_c;
  end
  assign irq_w1c = (req.wr && (req.addr == ISM_OFS_IRQST)) ? req.wdata[ISM_NEV-1:0] : '0;

  // sticky status, write one to clear, a new event wins over the clear
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_st_q <= '0;
    end else begin
      irq_st_q <= (irq_st_q & ~irq_w1c) | ev;
    end
  end

  // interrupt mask register
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_msk_q <= ISM_IRQMSK_RST;
    end else if (req.wr && (req.addr == ISM_OFS_IRQMSK)) begin
      irq_msk_q <= req.wdata[ISM_NEV-1:0];
    end
  end

  // level interrupt, one cycle behind the status
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_st_q & irq_msk_q);
    end
  end

  // read decode; unmapped addresses answer zero
  always_comb begin
    rd_mux = ISM_RD_ZERO;
    case (req.addr)
      ISM_OFS_STATUS: rd_mux[ISM_ST_STOP:ISM_ST_TXFULL] = status_q;
      ISM_OFS_MASK: rd_mux[ISM_ADRW-1:0] = address_bit_mask_q; // [R12]
      ISM_OFS_RXBUF: rd_mux[7:0] = rx_buf_q;
      ISM_OFS_TXBUF: rd_mux[7:0] = tx_byte_o;
      ISM_OFS_OWNADR: rd_mux[ISM_ADRW-1:0] = own_adr_q;
      ISM_OFS_IRQST: rd_mux[ISM_NEV-1:0] = irq_st_q;
      ISM_OFS_IRQMSK: rd_mux[ISM_NEV-1:0] = irq_msk_q;
      default: rd_mux = ISM_RD_ZERO;
    endcase
  end

  // read data stand one cycle after the strobe and only then
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= ISM_RD_ZERO;
    end else if (req.rd) begin
      reg_rdata_o <= rd_mux;
    end else begin
      reg_rdata_o <= ISM_RD_ZERO;
    end
  end

  // checks on the flag and compare behaviour
  sequence s_tx_write;
    wr_tx;
  endsequence
  sequence s_tx_full_hold;
    status_q.transmit_buffer_full_flag && !wr_tx && !tx_done_i;
  endsequence

  property p_start_flag;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    start_det |=> status_q.start_seen && !status_q.stop_seen;
  endproperty
  a_start_flag: assert property (p_start_flag) else $error("start flag wrong"); // [R1]

  property p_stop_flag;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    stop_det && !start_det |=> status_q.stop_seen && !status_q.start_seen;
  endproperty
  a_stop_flag: assert property (p_stop_flag) else $error("stop flag wrong"); // [R2]

  property p_cond_hold;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    !start_det && !stop_det |=> $stable(status_q.start_seen) && $stable(status_q.stop_seen);
  endproperty
  a_cond_hold: assert property (p_cond_hold) else $error("start flag moved alone"); // [R3]

  property p_dir_load;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    adr_byte_valid_i |=> status_q.slave_read == $past(adr_byte_rw_i);
  endproperty
  a_dir_load: assert property (p_dir_load) else $error("direction not loaded"); // [R4]

  property p_dir_hold;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    !adr_byte_valid_i |=> $stable(status_q.slave_read);
  endproperty
  a_dir_hold: assert property (p_dir_hold) else $error("direction moved"); // [R5]

  property p_rxfull_set;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    rx_byte_valid_i |=> status_q.receive_buffer_full_flag && rx_buf_q == $past(rx_byte_i);
  endproperty
  a_rxfull_set: assert property (p_rxfull_set) else $error("receive full not set"); // [R6]

  property p_rxfull_clr;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    rd_rx && !rx_byte_valid_i |=> !status_q.receive_buffer_full_flag;
  endproperty
  a_rxfull_clr: assert property (p_rxfull_clr) else $error("receive full not cleared"); // [R7]

  property p_txfull_set;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    s_tx_write |=> status_q.transmit_buffer_full_flag ##0 tx_load_o;
  endproperty
  a_txfull_set: assert property (p_txfull_set) else $error("transmit full not set"); // [R8]

  property p_txfull_clr;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    s_tx_full_hold ##1 (tx_done_i && !wr_tx) |=> !status_q.transmit_buffer_full_flag;
  endproperty
  a_txfull_clr: assert property (p_txfull_clr) else $error("transmit full not cleared"); // [R9]

  property p_mask_all;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    adr_cmp_valid_i && (&address_bit_mask_q) |=> adr_match_o && adr_match_valid_o;
  endproperty
  a_mask_all: assert property (p_mask_all) else $error("fully masked compare failed"); // [R10]

  property p_mask_none;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    adr_cmp_valid_i && address_bit_mask_q == '0 && adr_in_i[0] != own_adr_q[0] |=> !adr_match_o;
  endproperty
  a_mask_none: assert property (p_mask_none) else $error("unmasked mismatch matched"); // [R11]

  property p_mask_upper;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    req.rd && req.addr == ISM_OFS_MASK |=> reg_rdata_o[15:10] == 6'h00;
  endproperty
  a_mask_upper: assert property (p_mask_upper) else $error("mask upper bits not zero"); // [R12]

  property p_seven_bit;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    adr_cmp_valid_i && !adr_ten_bit_i && (&address_bit_mask_q[6:0]) |=> adr_match_o;
  endproperty
  a_seven_bit: assert property (p_seven_bit) else $error("seven-bit compare used high bits"); // [R13]
endmodule

// ---- tb/ism_bus_model.sv ----
// partner model: another bus master making start, repeated start and stop
`timescale 1ns/1ps
module ism_bus_model (
  // wires toward the block, pulled up when released
  output logic scl_o,
  output logic sda_o
);
  // half period of the 125 ns link clock
  localparam realtime STEP = 62.5;

  // idle bus: both lines released to the pull-up level
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  // data falls while clock high; works from idle or mid-frame
  task automatic start_cond();
    sda_o = 1'b1;
    #STEP;
    scl_o = 1'b1;
    #STEP;
    sda_o = 1'b0;
    #STEP;
    scl_o = 1'b0;
    #STEP;
  endtask

  // data rises while clock high, bus left idle afterwards
  task automatic stop_cond();
    sda_o = 1'b0;
    #STEP;
    scl_o = 1'b1;
    #STEP;
    sda_o = 1'b1;
    #STEP;
  endtask
endmodule

// ---- tb/test_ism_top.sv ----
// testbench of the status flags and address mask block
`timescale 1ns/1ps
module test_ism_top;
  import ism_pkg::*;
  // clock, reset and register port
  logic sys_clk;
  logic rst_n;
  logic [ISM_AW-1:0] reg_addr;
  logic [ISM_DW-1:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [ISM_DW-1:0] reg_rdata;
  // bus wires from the partner
  logic scl;
  logic sda;
  // sequencer side
  logic rx_valid;
  logic [7:0] rx_byte;
  logic adr_valid;
  logic adr_rw;
  logic tx_done;
  logic cmp_valid;
  logic [ISM_ADRW-1:0] adr_in;
  logic ten_bit;
  logic [7:0] tx_byte;
  logic tx_load;
  logic match;
  logic match_valid;
  logic irq;
  // bookkeeping
  int err_count;
  int n_compared;
  logic [31:0] rd_val;

  ism_top ism_top_i (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
    .scl_i(scl), .sda_i(sda), .rx_byte_valid_i(rx_valid), .rx_byte_i(rx_byte),
    .adr_byte_valid_i(adr_valid), .adr_byte_rw_i(adr_rw), .tx_done_i(tx_done),
    .adr_cmp_valid_i(cmp_valid), .adr_in_i(adr_in), .adr_ten_bit_i(ten_bit),
    .tx_byte_o(tx_byte), .tx_load_o(tx_load), .adr_match_o(match),
    .adr_match_valid_o(match_valid), .irq_o(irq));

  ism_bus_model ism_bus_model_i (.scl_o(scl), .sda_o(sda));

  // 125 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // compare and count; four-state so unknowns never match
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // one-cycle read strobe; data taken in the following cycle only
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    rd_val = reg_rdata;
  endtask

  // reset values and an unmapped place
  task automatic test_reset();
    rd(ISM_OFS_STATUS);
    check(rd_val, 32'h0000_0000);
    rd(ISM_OFS_MASK);
    check(rd_val, 32'h0000_0000);
    rd(8'h1c);
    check(rd_val, 32'h0000_0000);
    $display("test reset done");
  endtask

  // start, repeated start, stop and the interrupt path
  task automatic test_cond();
    ism_bus_model_i.start_cond();
    repeat (6) @(posedge sys_clk);
    rd(ISM_OFS_STATUS);
    check({rd_val[ISM_ST_STOP], rd_val[ISM_ST_START]}, 2'b01);
    check(irq, 1'b0);
    wr(ISM_OFS_IRQMSK, 32'h0000_0001);
    repeat (2) @(posedge sys_clk);
    #1;
    check(irq, 1'b1);
    wr(ISM_OFS_IRQST, 32'h0000_0001);
    repeat (2) @(posedge sys_clk);
    #1;
    check(irq, 1'b0);
    // repeated start straight out of a frame
    ism_bus_model_i.start_cond();
    ism_bus_model_i.stop_cond();
    repeat (6) @(posedge sys_clk);
    rd(ISM_OFS_STATUS);
    check({rd_val[ISM_ST_STOP], rd_val[ISM_ST_START]}, 2'b10);
    rd(ISM_OFS_IRQST);
    check(rd_val, 32'h0000_0003);
    wr(ISM_OFS_IRQST, 32'h0000_001f);
    ism_bus_model_i.start_cond();
    repeat (6) @(posedge sys_clk);
    rd(ISM_OFS_STATUS);
    check({rd_val[ISM_ST_STOP], rd_val[ISM_ST_START]}, 2'b01);
    $display("test conditions done");
  endtask

  // direction flag loads only from the address byte
  task automatic test_dir();
    @(posedge sys_clk);
    adr_valid <= 1'b1;
    adr_rw <= 1'b1;
    @(posedge sys_clk);
    adr_valid <= 1'b0;
    adr_rw <= 1'b0;
    rd(ISM_OFS_STATUS);
    check(rd_val[ISM_ST_RW], 1'b1);
    @(posedge sys_clk);
    adr_valid <= 1'b1;
    @(posedge sys_clk);
    adr_valid <= 1'b0;
    adr_rw <= 1'b1;
    rd(ISM_OFS_STATUS);
    check(rd_val[ISM_ST_RW], 1'b0);
    $display("test direction done");
  endtask

  // receive full set by stored byte, cleared by buffer read
  task automatic test_rx();
    @(posedge sys_clk);
    rx_valid <= 1'b1;
    rx_byte <= 8'h5a;
    @(posedge sys_clk);
    rx_valid <= 1'b0;
    rd(ISM_OFS_STATUS);
    check(rd_val[ISM_ST_RXFULL], 1'b1);
    rd(ISM_OFS_RXBUF);
    check(rd_val, 32'h0000_005a);
    rd(ISM_OFS_STATUS);
    check(rd_val[ISM_ST_RXFULL], 1'b0);
    $display("test receive done");
  endtask

  // transmit full set by buffer write, cleared on completion
  task automatic test_tx();
    wr(ISM_OFS_TXBUF, 32'h0000_00a5);
    #1;
    check({tx_load, tx_byte}, 9'h1a5);
    rd(ISM_OFS_STATUS);
    check(rd_val[ISM_ST_TXFULL], 1'b1);
    @(posedge sys_clk);
    tx_done <= 1'b1;
    @(posedge sys_clk);
    tx_done <= 1'b0;
    rd(ISM_OFS_STATUS);
    check(rd_val[ISM_ST_TXFULL], 1'b0);
    $display("test transmit done");
  endtask

  // masked compare against own address 0x2a5; entries {exp, ten, mask, adr}
  task automatic test_mask();
    logic [21:0] tbl [10] = '{{2'b11, 10'h000, 10'h2a5}, {2'b01, 10'h000, 10'h2a4},
      {2'b11, 10'h001, 10'h2a4}, {2'b11, 10'h200, 10'h0a5}, {2'b01, 10'h000, 10'h0a5},
      {2'b10, 10'h000, 10'h0a5}, {2'b00, 10'h000, 10'h024}, {2'b10, 10'h001, 10'h024},
      {2'b11, 10'h3ff, 10'h15a}, {2'b10, 10'h07f, 10'h35a}};
    wr(ISM_OFS_MASK, 32'hffff_ffff);
    rd(ISM_OFS_MASK);
    check(rd_val, 32'h0000_03ff);
    wr(ISM_OFS_OWNADR, 32'h0000_02a5);
    for (int i = 0; i < 10; i++) begin
      wr(ISM_OFS_MASK, {22'h0, tbl[i][19:10]});
      @(posedge sys_clk);
      ten_bit <= tbl[i][20];
      adr_in <= tbl[i][9:0];
      cmp_valid <= 1'b1;
      @(posedge sys_clk);
      cmp_valid <= 1'b0;
      #1;
      check({match_valid, match}, {1'b1, tbl[i][21]});
    end
    $display("test mask done");
  endtask

  // verdict and end of run
  task automatic final_report();
    $display("compared %0d, mismatched %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // watchdog, well beyond the expected few microseconds
  initial begin
    #200000;
    err_count++;
    $display("watchdog expired");
    final_report();
  end

  // main sequence
  initial begin
    err_count = 0;
    n_compared = 0;
    rst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    rx_valid = 1'b0;
    rx_byte = 8'h00;
    adr_valid = 1'b0;
    adr_rw = 1'b0;
    tx_done = 1'b0;
    cmp_valid = 1'b0;
    adr_in = 10'h000;
    ten_bit = 1'b0;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    test_reset();
    test_cond();
    test_dir();
    test_rx();
    test_tx();
    test_mask();
    final_report();
  end
endmodule
